// [hw/tsfc_pkg.sv]
/*
 * Shared constants of the two-speed start-up and fail-safe clock supervisor:
 * register offsets, field positions, reset values, counts and encodings.
 * Assumes nothing of its surroundings; it is compiled before every other file.
 */
package tsfc_pkg;

	// Byte addresses of the two APB registers.
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FAIL_STAT = 8'h04;

	// Field positions in the oscillator control register.
	localparam int SCS_LSB = 0;
	localparam int INTERNAL_OSC_STABLE_BIT = 2;
	localparam int PRIMARY_RUNNING_STATUS_BIT = 3;
	localparam int INTERNAL_FREQ_SELECT_LSB = 4;

	// Field positions in the fail status register.
	localparam int FLAG_BIT = 0;
	localparam int INT_EN_BIT = 1;
	localparam int FAILSAFE_BIT = 2;
	localparam int LOW_POWER_BIT = 3;

	// Values after reset.
	localparam logic [1:0] SCS_RESET = 2'h0;
	localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h0;

	// System clock select encodings.
	localparam logic [1:0] SCS_PRIMARY = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [1:0] SCS_FAIL_FORCE = 2'h2;

	// Start-up timer length and hold-low length, in primary falling edges.
	localparam logic [10:0] OST_LAST = 11'h3ff;
	localparam logic [3:0] HOLD_LAST = 4'h7;

	// Monitor sample clock divides the reference by 64.
	localparam logic [5:0] DIV_RISE = 6'h1f;
	localparam logic [5:0] DIV_FALL = 6'h3f;

	// Primary oscillator modes from the configuration word.
	typedef enum logic [2:0] {
		LOW_POWER_CRYSTAL_MODE,
		STANDARD_CRYSTAL_MODE,
		HIGH_SPEED_CRYSTAL_MODE,
		EXTERNAL_CLOCK_INPUT_MODE,
		RESISTOR_CAPACITOR_MODE
	} tsfc_mode_e;

	// Source that the clock multiplexer passes to the core.
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_INTERNAL,
		SRC_PRIMARY,
		SRC_SECONDARY
	} tsfc_src_e;

endpackage : tsfc_pkg

// [hw/tsfc_mon_if.sv]
/*
 * Link between the supervisor control and the clock monitor.
 * Assumes both ends run on the same reference clock.
 */
`timescale 1ns/1ps
interface tsfc_mon_if;
	logic enable; // Monitor armed.
	logic clk_level; // Sampled level of the monitored system clock.
	logic fail; // One-cycle pulse: clock failure seen.
	logic seen; // Clock-seen latch state.

	// Control side drives the enable and the level.
	modport ctrl (output enable, output clk_level, input fail, input seen);
	// Monitor side answers with the failure pulse.
	modport mon (input enable, input clk_level, output fail, output seen);
endinterface : tsfc_mon_if

// [hw/tsfc_monitor.sv]
/*
 * Fail-safe clock monitor: divides the reference by 64 into a sample clock
 * and checks that the system clock fell between each sample rise and the sample fall after it.
 * Assumes the monitored level is registered and synchronous to clock_in.
 */
`timescale 1ns/1ps
module tsfc_monitor (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Control link.
	tsfc_mon_if.mon mon
);

	// All monitor state in one word.
	typedef struct packed {
		logic [5:0] div; // Sample clock divider.
		logic prev; // Previous system clock level.
		logic seen; // Clock-seen latch.
		logic fail; // Failure pulse.
	} tsfc_mon_s;

	tsfc_mon_s s;
	tsfc_mon_s next_s;
	logic sys_fall; // System clock fell this cycle.

	// Divider, latch and decision.
	always_comb begin
		next_s = s;
		sys_fall = s.prev & ~mon.clk_level;
		next_s.prev = mon.clk_level;
		next_s.fail = 1'b0;
		next_s.div = 6'(s.div + 6'h01); // [R16]
		if (!mon.enable) begin
			// A disarmed monitor counts as having seen a clock, so no false alarm.
			next_s.seen = 1'b1;
		end else begin
			if (s.div == tsfc_pkg::DIV_RISE) begin
				next_s.seen = 1'b0; // [R17]
			end
			if (sys_fall) begin
				next_s.seen = 1'b1; // [R17]
			end
			if (s.div == tsfc_pkg::DIV_FALL && !s.seen && !sys_fall) begin
				next_s.fail = 1'b1; // [R18]
			end
		end
	end

	// State register.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s <= '{div: 6'h00, prev: 1'b0, seen: 1'b1, fail: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign mon.fail = s.fail;
	assign mon.seen = s.seen;

	// Failure only after half a sample period, from sample rise to sample fall, without an edge.
	a_fail_needs_gap: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R18]
		mon.fail |-> $past(s.div) == tsfc_pkg::DIV_FALL && !$past(s.seen))
		else $error("monitor failed with the latch set");

	// No failure in the eight cycles after a failure.
	a_fail_spacing: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R16]
		mon.fail |=> (!mon.fail) [*8])
		else $error("monitor failures too close together");

	// A falling system clock sets the latch.
	a_latch_sets: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [R17]
		(mon.enable && s.prev && !mon.clk_level) |=> s.seen)
		else $error("latch missed a falling clock edge");

endmodule : tsfc_monitor

// [hw/tsfc_top.sv]
/*
 * Two-speed start-up and fail-safe clock supervisor with an APB register port.
 * Assumes clock_in is the internal RC reference, and that the primary and
 * secondary clock levels, the straps and the core events are synchronous to it.
 */
// Function
// R1: Switch-over runs internal clock until primary stable.
// R2: Start internally after power-up, wake, reset.
// R3: Every reset zeroes the clock source select.
// R4: Internal start uses the lowest internal frequency; on wake the code keeps the frequency field as last written.
// R5: Two-speed start needs a crystal primary mode.
// R6: Nonzero frequency before sleep selects internal oscillator; the code ignores the frequency field on wake.
// R7: Primary running status clear unless primary engaged.
// R8: Source select writable before start-up timer ends.
// R9: Sleep aborts start-up count, status stays clear.
// R10: Internal clock first, then count 1024 edges.
// R11: Set status, hold low eight edges, switch.
// R12: Monitor works only when its enable set.
// R13: Failure raises flag and forces internal clock.
// R14: Reset, sleep or control write end fail-safe.
// R15: Fail-safe frequency follows the frequency select field.
// R16: Sample clock is reference divided by 64.
// R17: Latch clears on sample rise, sets on clock fall.
// R18: Sample fall with latch clear means failure.
// R19: Crystal reset in fail-safe waits the timer internally.
// R20: External or RC reset returns to primary immediately.
// R21: Sleep or nonzero select enters low-power mode.
// R22: Monitor enable also enables two-speed start.
// R23: Failure forces select to binary one-zero, clears watchdog.
// R24: Interrupt reaches core only when enabled.
// R25: Fail flag sticks until software clears it.
`timescale 1ns/1ps
module tsfc_top (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_n_in,
	// APB slave port.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Configuration word straps.
	input wire logic switch_over_enable_in,
	input wire logic fail_monitor_enable_in,
	input wire logic [2:0] primary_mode_in,
	input wire logic watchdog_enable_in,
	// Core and power events.
	input wire logic power_up_done_in,
	input wire logic sleep_in,
	input wire logic wake_in,
	// Oscillator sense.
	input wire logic primary_clk_in,
	input wire logic secondary_clk_in,
	input wire logic internal_osc_ready_in,
	// Clock control results.
	output logic [1:0] sys_clk_src_out,
	output logic [2:0] internal_freq_select_out,
	output logic primary_running_status_out,
	output logic fail_safe_active_out,
	output logic low_power_out,
	output logic osc_fail_irq_out,
	output logic wdt_clear_out
);

	// Phases of the clock supervisor.
	typedef enum logic [2:0] {
		ST_BOOT,
		ST_INTERNAL,
		ST_WAIT_EDGE,
		ST_HOLD,
		ST_PRIMARY,
		ST_ALT,
		ST_FAILSAFE,
		ST_SLEEP
	} tsfc_phase_e;

	// All supervisor state in one word.
	typedef struct packed {
		tsfc_phase_e phase; // Supervisor phase.
		logic woke; // Boot follows a wake-up or a control write back to the primary, so the power-up timer is done.
		logic [1:0] scs; // System clock select.
		logic [2:0] internal_freq_select; // Internal frequency select.
		logic primary_running_status; // Primary running status.
		logic internal_osc_stable; // Internal oscillator stable.
		logic fail_flag; // Oscillator fail flag.
		logic int_en; // Oscillator fail interrupt enable.
		logic failsafe; // Fail-safe condition active.
		logic low_power; // Low-power mode.
		logic [10:0] ost_cnt; // Start-up timer.
		logic [3:0] hold_cnt; // Hold-low edge counter.
		logic prim_prev; // Previous primary level.
		tsfc_pkg::tsfc_src_e src; // Clock source passed to the core.
		logic irq; // Gated interrupt request.
		logic wdt_clr; // Watchdog clear pulse.
		logic mon_en; // Monitor armed.
		logic mon_level; // Monitored clock level.
		logic pready; // APB ready.
		logic pslverr; // APB error.
		logic [31:0] prdata; // APB read data.
	} tsfc_state_s;

	tsfc_state_s s;
	tsfc_state_s next_s;
	logic prim_fall; // Primary clock fell this cycle.
	logic crystal; // Primary is a crystal or resonator.
	logic two_speed; // Two-speed start-up in force.
	logic access; // APB access phase being answered now.
	logic wr_ctrl; // Write to the control register takes effect.
	logic wr_stat; // Write to the status register takes effect.
	logic [31:0] rd_word; // Read data for the current address.

	tsfc_mon_if mon_link ();

	// The monitor checks whichever external clock is now the system clock.
	tsfc_monitor u_monitor (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.mon(mon_link.mon)
	);

	assign mon_link.enable = s.mon_en;
	assign mon_link.clk_level = s.mon_level;

	// Decode of mode straps and APB strobes.
	always_comb begin
		prim_fall = s.prim_prev & ~primary_clk_in;
		crystal = primary_mode_in == tsfc_pkg::LOW_POWER_CRYSTAL_MODE ||
			primary_mode_in == tsfc_pkg::STANDARD_CRYSTAL_MODE ||
			primary_mode_in == tsfc_pkg::HIGH_SPEED_CRYSTAL_MODE;
		// The monitor enable drags two-speed start-up in with it.
		two_speed = (switch_over_enable_in | fail_monitor_enable_in) & crystal; // [R5] [R22]
		access = psel_in & penable_in;
		// Writes act only on the edge where the master sees ready.
		wr_ctrl = access & s.pready & pwrite_in & paddr_in == tsfc_pkg::ADDR_OSC_CTRL;
		wr_stat = access & s.pready & pwrite_in & paddr_in == tsfc_pkg::ADDR_FAIL_STAT;
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr_in)
			tsfc_pkg::ADDR_OSC_CTRL: begin
				rd_word[tsfc_pkg::SCS_LSB +: 2] = s.scs;
				rd_word[tsfc_pkg::INTERNAL_OSC_STABLE_BIT] = s.internal_osc_stable; // [R6]
				rd_word[tsfc_pkg::PRIMARY_RUNNING_STATUS_BIT] = s.primary_running_status; // [R7]
				rd_word[tsfc_pkg::INTERNAL_FREQ_SELECT_LSB +: 3] = s.internal_freq_select;
			end
			tsfc_pkg::ADDR_FAIL_STAT: begin
				rd_word[tsfc_pkg::FLAG_BIT] = s.fail_flag;
				rd_word[tsfc_pkg::INT_EN_BIT] = s.int_en;
				rd_word[tsfc_pkg::FAILSAFE_BIT] = s.failsafe;
				rd_word[tsfc_pkg::LOW_POWER_BIT] = s.low_power;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Next-state logic: sequence, software writes, sleep, failure, bus.
	always_comb begin
		next_s = s;
		next_s.prim_prev = primary_clk_in;
		next_s.internal_osc_stable = internal_osc_ready_in; // [R6]
		next_s.wdt_clr = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;

		// Start-up sequence.
		case (s.phase)
			ST_BOOT: begin
				if (power_up_done_in || s.woke) begin
					next_s.woke = 1'b0;
					next_s.ost_cnt = 11'h000;
					next_s.primary_running_status = 1'b0; // [R7]
					if (crystal) begin
						// The frequency field is zero after reset, the lowest rate. [R4]
						next_s.phase = ST_INTERNAL; // [R1] [R2] [R10] [R19]
						// Without two-speed the core waits for the timer unclocked.
						next_s.src = two_speed ? tsfc_pkg::SRC_INTERNAL : tsfc_pkg::SRC_NONE;
					end else begin
						// External clock and RC need no settling time. [R20]
						next_s.phase = ST_PRIMARY;
						next_s.src = tsfc_pkg::SRC_PRIMARY;
						next_s.primary_running_status = 1'b1;
					end
				end
			end
			ST_INTERNAL: begin
				if (prim_fall) begin
					next_s.ost_cnt = 11'(s.ost_cnt + 11'h001); // [R10]
					if (s.ost_cnt == tsfc_pkg::OST_LAST) begin
						next_s.phase = ST_WAIT_EDGE;
					end
				end
			end
			ST_WAIT_EDGE: begin
				// One reference cycle stands for the falling internal edge.
				next_s.primary_running_status = 1'b1; // [R11]
				next_s.src = tsfc_pkg::SRC_NONE; // [R11]
				next_s.hold_cnt = 4'h0;
				next_s.phase = ST_HOLD;
			end
			ST_HOLD: begin
				if (prim_fall) begin
					next_s.hold_cnt = 4'(s.hold_cnt + 4'h1);
					if (s.hold_cnt == tsfc_pkg::HOLD_LAST) begin
						next_s.phase = ST_PRIMARY; // [R11]
						next_s.src = tsfc_pkg::SRC_PRIMARY; // [R1]
					end
				end
			end
			ST_SLEEP: begin
				if (wake_in) begin
					next_s.low_power = 1'b0;
					next_s.woke = 1'b1;
					// Wake re-runs the boot; the frequency field plays no part in the source chosen.
					next_s.phase = ST_BOOT; // [R2] [R6]
				end
			end
			ST_PRIMARY, ST_ALT, ST_FAILSAFE: begin
				next_s.phase = s.phase;
			end
			default: begin
				next_s.phase = ST_BOOT;
			end
		endcase

		// Control register write; allowed even during start-up.
		if (wr_ctrl) begin
			next_s.scs = pwdata_in[tsfc_pkg::SCS_LSB +: 2]; // [R8]
			next_s.internal_freq_select = pwdata_in[tsfc_pkg::INTERNAL_FREQ_SELECT_LSB +: 3]; // [R15]
			next_s.failsafe = 1'b0; // [R14]
			if (pwdata_in[tsfc_pkg::SCS_LSB +: 2] != tsfc_pkg::SCS_PRIMARY) begin
				// A switch away aborts any start-up and saves power. [R21]
				next_s.phase = ST_ALT;
				next_s.low_power = 1'b1;
				next_s.primary_running_status = 1'b0; // [R7]
				if (pwdata_in[tsfc_pkg::SCS_LSB +: 2] == tsfc_pkg::SCS_SECONDARY) begin
					next_s.src = tsfc_pkg::SRC_SECONDARY;
				end else begin
					next_s.src = tsfc_pkg::SRC_INTERNAL;
				end
			end else if (s.phase == ST_ALT || s.phase == ST_FAILSAFE) begin
				// Going back to the primary re-runs the start-up.
				next_s.low_power = 1'b0;
				next_s.woke = 1'b1;
				next_s.phase = ST_BOOT;
			end
		end

		// Sleep overrides the phase, source and status set by any write: the start-up count is thrown away.
		if (sleep_in && s.phase != ST_SLEEP) begin
			next_s.phase = ST_SLEEP; // [R9]
			next_s.primary_running_status = 1'b0; // [R9]
			next_s.failsafe = 1'b0; // [R14]
			next_s.low_power = 1'b1; // [R21]
			next_s.src = tsfc_pkg::SRC_NONE;
		end

		// A detected failure wins over everything but sleep.
		if (mon_link.fail && !sleep_in && (s.phase == ST_PRIMARY || s.phase == ST_ALT)) begin
			next_s.phase = ST_FAILSAFE; // [R13]
			next_s.failsafe = 1'b1; // [R13]
			next_s.src = tsfc_pkg::SRC_INTERNAL; // [R13] [R15]
			next_s.scs = tsfc_pkg::SCS_FAIL_FORCE; // [R23]
			next_s.wdt_clr = watchdog_enable_in; // [R23]
			next_s.primary_running_status = 1'b0; // [R7]
		end

		// Status register: enable is plain, flag is write-one-to-clear.
		if (wr_stat) begin
			next_s.int_en = pwdata_in[tsfc_pkg::INT_EN_BIT];
			if (pwdata_in[tsfc_pkg::FLAG_BIT]) begin
				next_s.fail_flag = 1'b0; // [R25]
			end
		end
		// Set after clear so that a failure in the clearing cycle survives.
		if (mon_link.fail && (s.phase == ST_PRIMARY || s.phase == ST_ALT)) begin
			next_s.fail_flag = 1'b1; // [R13] [R25]
		end
		next_s.irq = next_s.fail_flag & next_s.int_en; // [R24]

		// Arm the monitor only on an external system clock.
		next_s.mon_en = fail_monitor_enable_in & (next_s.phase == ST_PRIMARY ||
			(next_s.phase == ST_ALT && next_s.src == tsfc_pkg::SRC_SECONDARY)); // [R12]
		next_s.mon_level = (next_s.src == tsfc_pkg::SRC_SECONDARY) ?
			secondary_clk_in : primary_clk_in;

		// APB answer one cycle into the access phase.
		if (access && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.prdata = rd_word;
			next_s.pslverr = paddr_in != tsfc_pkg::ADDR_OSC_CTRL &&
				paddr_in != tsfc_pkg::ADDR_FAIL_STAT;
		end
	end

	// State register; reset loads constants only.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.phase <= ST_BOOT; // [R2]
			s.scs <= tsfc_pkg::SCS_RESET; // [R3]
			s.internal_freq_select <= tsfc_pkg::INTERNAL_FREQ_SELECT_RESET; // [R4]
			s.src <= tsfc_pkg::SRC_NONE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register.
	assign prdata_out = s.prdata;
	assign pready_out = s.pready;
	assign pslverr_out = s.pslverr;
	assign sys_clk_src_out = s.src;
	assign internal_freq_select_out = s.internal_freq_select;
	assign primary_running_status_out = s.primary_running_status;
	assign fail_safe_active_out = s.failsafe;
	assign low_power_out = s.low_power;
	assign osc_fail_irq_out = s.irq;
	assign wdt_clear_out = s.wdt_clr;

	// Checks of the supervisor behaviour.
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	// Start-up timer ran out on the last primary edge of its count.
	sequence seq_ost_done;
		s.phase == ST_INTERNAL && prim_fall && s.ost_cnt == tsfc_pkg::OST_LAST &&
			!sleep_in && !wr_ctrl;
	endsequence

	// Nothing interrupts the hand-over cycle.
	sequence seq_quiet;
		!sleep_in && !wr_ctrl;
	endsequence

	a_reset_select_zero: assert property ($past(!rst_n_in) |-> s.scs == 2'h0) // [R3]
		else $error("select field not zero after reset");

	a_switch_order: assert property (seq_ost_done ##1 seq_quiet |=> // [R11]
		s.phase == ST_HOLD && s.primary_running_status && s.src == tsfc_pkg::SRC_NONE)
		else $error("status not set or clock not held after timer expiry");

	a_hold_edges: assert property ((s.phase == ST_HOLD && prim_fall && // [R11]
		s.hold_cnt == 4'h7 && !sleep_in && !wr_ctrl) |=>
		s.src == tsfc_pkg::SRC_PRIMARY && s.primary_running_status)
		else $error("no switch after eight held edges");

	a_status_clear: assert property ((s.src != tsfc_pkg::SRC_PRIMARY && // [R7]
		s.phase != ST_HOLD) |-> !s.primary_running_status)
		else $error("running status set without primary clock");

	a_sleep_aborts: assert property ((sleep_in && s.phase != ST_SLEEP) |=> // [R9]
		s.phase == ST_SLEEP && !s.primary_running_status && s.low_power && !s.failsafe)
		else $error("sleep did not abort the start-up");

	a_fail_forces: assert property ((mon_link.fail && !sleep_in && // [R23]
		s.phase == ST_PRIMARY) |=> s.scs == 2'h2 && s.failsafe &&
		s.src == tsfc_pkg::SRC_INTERNAL && s.fail_flag && wdt_clear_out == $past(watchdog_enable_in))
		else $error("failure did not force the internal clock");

	a_irq_gated: assert property (osc_fail_irq_out |-> s.int_en && s.fail_flag) // [R24]
		else $error("interrupt raised while disabled");

	a_flag_sticky: assert property ((s.fail_flag && !(wr_stat && pwdata_in[0])) |=> // [R25]
		s.fail_flag)
		else $error("fail flag dropped without a clear");

	a_write_exits: assert property ((wr_ctrl && !sleep_in && !mon_link.fail) |=> // [R14]
		!s.failsafe)
		else $error("control write did not end fail-safe");

	a_no_two_speed: assert property ((s.phase == ST_BOOT && power_up_done_in && !crystal) // [R20]
		|=> s.phase == ST_PRIMARY || s.phase == ST_SLEEP || s.phase == ST_ALT)
		else $error("external clock did not start at once");

	a_monitor_gate: assert property (!fail_monitor_enable_in |=> !s.mon_en) // [R12]
		else $error("monitor armed while disabled");

	// A disarmed monitor keeps its latch set, so arming it cannot raise a false alarm.
	a_disarm_seen: assert property (!s.mon_en |=> mon_link.seen) // [R12]
		else $error("monitor latch not held set while disarmed");

endmodule : tsfc_top

// [verif/tsfc_osc_model.sv]
/*
 * Behavioural model of the primary and secondary oscillators seen by the supervisor.
 * Assumes clock_in is the reference clock; levels change just after its rising edge.
 */
`timescale 1ns/1ps
module tsfc_osc_model (
	// Reference clock.
	input wire logic clock_in,
	// Run controls from the bench.
	input wire logic primary_run_in,
	input wire logic secondary_run_in,
	// Oscillator levels.
	output logic primary_clk_out,
	output logic secondary_clk_out
);
	logic [1:0] div = 2'h0; // Free running divider of the reference.
	initial primary_clk_out = 1'b0;
	initial secondary_clk_out = 1'b0;

	// A stopped crystal freezes at its last level, which is what the monitor must catch.
	// The primary toggles every second cycle, slower than half the reference.
	always @(posedge clock_in) begin
		div <= div + 2'h1;
		if (primary_run_in && div[0]) begin
			primary_clk_out <= ~primary_clk_out;
		end
		if (secondary_run_in && div == 2'h3) begin
			secondary_clk_out <= ~secondary_clk_out;
		end
	end
endmodule : tsfc_osc_model

// [verif/tb.sv]
/*
 * Self-checking bench of the clock supervisor: boot table, start, failure, sleep, APB.
 * Assumes the oscillator model file is compiled before it.
 */
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0; // Reference clock, 40 MHz.
	logic rst_n = 1'b0; // Active low reset.
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, perr, err;
	logic so = 1'b1, fm = 1'b0, wde = 1'b1, pud = 1'b1, slp = 1'b0, wk = 1'b0, rdy = 1'b0;
	logic [2:0] mode = 3'h1, freq;
	logic prun = 1'b1, srun = 1'b1, pclk, sclk;
	logic [1:0] src;
	logic run_st, fs, lp, irq, wdc;
	int n_errors = 0, cmp_count = 0, wcnt = 0, wdt_seen = 0;
	// Boot table: straps and the source expected just after reset.
	typedef struct packed {logic so; logic fm; logic [2:0] mode; logic [1:0] src;} tsfc_row_s;
	tsfc_row_s rows [6] = '{'{1'b1, 1'b0, 3'h0, 2'h1}, '{1'b1, 1'b0, 3'h1, 2'h1},
		'{1'b1, 1'b0, 3'h2, 2'h1}, '{1'b1, 1'b0, 3'h3, 2'h2}, '{1'b1, 1'b0, 3'h4, 2'h2},
		'{1'b0, 1'b1, 3'h2, 2'h1}};

	always #12.5 clk = ~clk;

	tsfc_osc_model osc (.clock_in(clk), .primary_run_in(prun), .secondary_run_in(srun),
		.primary_clk_out(pclk), .secondary_clk_out(sclk));

	tsfc_top dut (.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(perr), .switch_over_enable_in(so),
		.fail_monitor_enable_in(fm), .primary_mode_in(mode), .watchdog_enable_in(wde),
		.power_up_done_in(pud), .sleep_in(slp), .wake_in(wk), .primary_clk_in(pclk),
		.secondary_clk_in(sclk), .internal_osc_ready_in(rdy), .sys_clk_src_out(src),
		.internal_freq_select_out(freq), .primary_running_status_out(run_st),
		.fail_safe_active_out(fs), .low_power_out(lp), .osc_fail_irq_out(irq),
		.wdt_clear_out(wdc));

	// Counts watchdog clear pulses, each one cycle long.
	always @(posedge clk) begin
		if (wdc === 1'b1) begin
			wdt_seen <= wdt_seen + 1;
		end
	end

	// Prints the counts and the verdict, then stops.
	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// Compares one value against its expectation.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is seen at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) begin
			@(posedge clk);
		end
		if (i == 20) begin
			n_errors++;
			close_out();
		end
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// Waits a bounded time for a watched output; the cycles taken land in wcnt.
	task wait_on(input int sel, input logic [1:0] v, input int lim);
		for (wcnt = 0; wcnt < lim; wcnt++) begin
			@(posedge clk);
			if ((sel == 0 && src === v) || (sel == 1 && fs === v[0])
				|| (sel == 2 && run_st === v[0])) begin
				return;
			end
		end
		n_errors++;
		close_out();
	endtask : wait_on

	// Holds reset for three cycles.
	task do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk(src, 2'h0);
		rst_n <= 1'b1;
	endtask : do_reset

	// Pulses one core event for a single cycle, then lets it land.
	task pulse(input int which);
		@(posedge clk);
		if (which == 0) begin
			slp <= 1'b1;
		end else begin
			wk <= 1'b1;
		end
		@(posedge clk);
		slp <= 1'b0;
		wk <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse

	initial begin
		// Boot source for every primary mode; only crystals start internally.
		foreach (rows[i]) begin
			so <= rows[i].so;
			fm <= rows[i].fm;
			mode <= rows[i].mode;
			do_reset();
			repeat (3) @(posedge clk);
			chk(src, rows[i].src);
		end
		// Full crystal start with the monitor armed.
		so <= 1'b1;
		mode <= 3'h1;
		do_reset();
		apb(1'b0, tsfc_pkg::ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(src, 2'h1);
		rdy <= 1'b1;
		wait_on(2, 2'h1, 6000);
		chk(wcnt > 4000, 1);
		chk(src, 2'h0);
		wait_on(0, 2'h2, 100);
		chk(wcnt >= 28 && wcnt <= 40, 1);
		apb(1'b0, tsfc_pkg::ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'hc);
		// Primary stops: the monitor must catch it within 140 reference cycles.
		prun <= 1'b0;
		wait_on(1, 2'h1, 140);
		repeat (2) @(posedge clk);
		chk(src, 2'h1);
		chk(wdt_seen, 1);
		apb(1'b0, tsfc_pkg::ADDR_OSC_CTRL, 32'h0);
		chk(rd[1:0], 2'h2);
		apb(1'b0, tsfc_pkg::ADDR_FAIL_STAT, 32'h0);
		chk(rd, 32'h5);
		chk(irq, 1'b0);
		apb(1'b1, tsfc_pkg::ADDR_FAIL_STAT, 32'h2);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		apb(1'b1, tsfc_pkg::ADDR_FAIL_STAT, 32'h3);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		// A control write ends fail-safe and picks the secondary at a raised frequency.
		prun <= 1'b1;
		apb(1'b1, tsfc_pkg::ADDR_OSC_CTRL, 32'h31);
		repeat (2) @(posedge clk);
		chk({fs, lp, src, freq}, {1'b0, 1'b1, 2'h3, 3'h3});
		pulse(0);
		chk({src, run_st, lp}, {2'h0, 1'b0, 1'b1});
		pulse(1);
		chk({src, freq}, {2'h1, 3'h3});
		apb(1'b1, tsfc_pkg::ADDR_OSC_CTRL, 32'h31);
		repeat (2) @(posedge clk);
		chk(src, 2'h3);
		// Select code two moves the core onto the internal clock in low-power mode.
		apb(1'b1, tsfc_pkg::ADDR_OSC_CTRL, 32'h32);
		repeat (2) @(posedge clk);
		chk({src, lp}, {2'h1, 1'b1});
		// Monitor disabled: a stopped clock raises nothing.
		fm <= 1'b0;
		mode <= 3'h3;
		do_reset();
		repeat (3) @(posedge clk);
		prun <= 1'b0;
		repeat (200) @(posedge clk);
		chk(fs, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		close_out();
	end
endmodule : tb
